//--- core/mw_pkg.sv
// package: register map, field positions and encodings of the motion-watch block
package mw_pkg;
  localparam int          MW_AW            = 8;
  localparam int          MW_DW            = 8;
  localparam logic [7:0]  MW_ADDR_THRESH   = 8'h13;  // shadow data port
  localparam logic [7:0]  MW_ADDR_CFG      = 8'h14;  // motion_watch_config
  localparam logic [7:0]  MW_ADDR_MODE     = 8'h13;  // mode bits share the shadow port, bits 7:6
  localparam logic [7:0]  MW_ADDR_STAT     = 8'h18;  // interrupt status
  localparam logic [7:0]  MW_ADDR_MASK     = 8'h19;  // interrupt mask
  localparam logic [7:0]  MW_CFG_RST       = 8'h00;
  localparam int          MW_SEL_LSB       = 0;
  localparam int          MW_CNTEN_BIT     = 3;
  localparam int          MW_WIN_LSB       = 4;
  localparam int          MW_MRST_BIT      = 7;
  localparam int          MW_AND_BIT       = 6;
  localparam int          MW_BASE_BIT      = 7;
  localparam logic [2:0]  MW_WIN_MAX       = 3'h5;
  localparam logic [2:0]  MW_SEL_TH_X      = 3'h1;
  localparam logic [2:0]  MW_SEL_CNT_X     = 3'h5;
  localparam int          MW_TH_W          = 6;
  localparam int          MW_DELTA_W       = 11;
  localparam int          MW_SAMPLE_W      = 14;
  localparam int          MW_AXES          = 3;
endpackage

//--- core/mw_axis.sv
// one axis: delta forming, window select with clamp, event counter
`timescale 1ns/1ps
module mw_axis
  import mw_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clr,
  input  wire logic                   sample_valid,
  input  wire logic [MW_SAMPLE_W-1:0] sample,
  input  wire logic                   baseline_mode,
  input  wire logic [2:0]             win_sel,
  input  wire logic [MW_TH_W-1:0]     thresh,
  input  wire logic [MW_TH_W-1:0]     count_m1,
  input  wire logic                   cnt_en,
  output logic                        hit
);
  logic [MW_SAMPLE_W-1:0] prev_q, prev_d, base_q, base_d;
  logic                   have_q, have_d, base_ok_q, base_ok_d;
  logic [MW_TH_W-1:0]     cnt_q, cnt_d;
  logic                   hit_q, hit_d;
  logic signed [MW_SAMPLE_W:0] diff;
  logic [MW_SAMPLE_W:0]   mag;
  logic [MW_DELTA_W-1:0]  delta;
  logic [MW_DELTA_W-1:0]  shifted;
  logic [2:0]             sh;
  logic [MW_TH_W-1:0]     win;
  logic                   over, event_now;

  always_comb begin
    diff = $signed({sample[MW_SAMPLE_W-1], sample})
         - $signed(baseline_mode ? {base_q[MW_SAMPLE_W-1], base_q}
                                 : {prev_q[MW_SAMPLE_W-1], prev_q});
    mag = diff[MW_SAMPLE_W] ? (~diff + 1'b1) : diff;
    delta = (|mag[MW_SAMPLE_W:MW_DELTA_W]) ? {MW_DELTA_W{1'b1}} : mag[MW_DELTA_W-1:0];
    sh = (win_sel > MW_WIN_MAX) ? MW_WIN_MAX : win_sel;
    shifted = delta >> sh;
    over = |shifted[MW_DELTA_W-1:MW_TH_W];
    win = over ? {MW_TH_W{1'b1}} : shifted[MW_TH_W-1:0];
    event_now = sample_valid && have_q && (over || win > thresh);
    prev_d = sample_valid ? sample : prev_q;
    have_d = have_q | sample_valid;
    base_ok_d = base_ok_q | sample_valid;
    base_d = (sample_valid && !base_ok_q) ? sample : base_q;
    cnt_d = cnt_q;
    hit_d = hit_q;
    if (event_now) begin
      if (!cnt_en || cnt_q >= count_m1) begin
        hit_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    if (clr) begin
      prev_d = '0;
      have_d = 1'b0;
      base_ok_d = 1'b0;
      base_d = '0;
      cnt_d = '0;
      hit_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_q <= '0;
      base_q <= '0;
      have_q <= 1'b0;
      base_ok_q <= 1'b0;
      cnt_q <= '0;
      hit_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      base_q <= base_d;
      have_q <= have_d;
      base_ok_q <= base_ok_d;
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end
  assign hit = hit_q;

  clr_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr |=> (hit_q == 1'b0 && cnt_q == '0)) else $error("clear left state");
endmodule

//--- core/mw_top.sv
// motion-watch configuration, shadow registers, detection and interrupt
`timescale 1ns/1ps
// How it works
// - bits 2:0 of the config register pick which threshold or count the shadow port reaches.
// - bit 3 enables the per-axis event counters, needed for a counted wakeup.
// - bits 6:4 pick which 6-bit slice of the 11-bit delta is compared, codes 5 to 7 alike.
// - a delta above the chosen slice is clamped so it still counts as an event.
// - bit 7 holds the watch block in reset while set and is never cleared by hardware.
// - the config register resets to all zeros.
// - each count shadow holds events minus one, per axis independently.
// - a combine bit chooses any-axis or all-axes wakeup.
// - a delta bit chooses current minus previous or current minus baseline.
module mw_top
  import mw_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [MW_AW-1:0]       reg_addr,
  input  wire logic [MW_DW-1:0]       reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [MW_DW-1:0]       reg_rdata,
  input  wire logic                   sample_valid,
  input  wire logic [MW_SAMPLE_W-1:0] sample_x,
  input  wire logic [MW_SAMPLE_W-1:0] sample_y,
  input  wire logic [MW_SAMPLE_W-1:0] sample_z,
  input  wire logic [MW_AXES-1:0]     axis_active,
  output logic                        wakeup,
  output logic                        irq
);
  logic [MW_DW-1:0]   cfg_q, cfg_d;
  logic [MW_TH_W-1:0] th_q [MW_AXES];
  logic [MW_TH_W-1:0] th_d [MW_AXES];
  logic [MW_TH_W-1:0] cnt_q [MW_AXES];
  logic [MW_TH_W-1:0] cnt_d [MW_AXES];
  logic               and_q, and_d, base_q, base_d;
  logic [MW_DW-1:0]   rdata_q, rdata_d;
  logic               wake_q, wake_d, stat_q, stat_d, mask_q, mask_d, irq_q, irq_d;
  logic [MW_AXES-1:0] hits;
  logic [2:0]         sel;
  logic               clr, any_hit, all_hit, wake_now;

  assign sel = cfg_q[MW_SEL_LSB +: 3];
  assign clr = cfg_q[MW_MRST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < MW_AXES; g++) begin : g_axis
      mw_axis u_axis (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .clr           (clr),
        .sample_valid  (sample_valid),
        .sample        (g == 0 ? sample_x : (g == 1 ? sample_y : sample_z)),
        .baseline_mode (base_q),
        .win_sel       (cfg_q[MW_WIN_LSB +: 3]),
        .thresh        (th_q[g]),
        .count_m1      (cnt_q[g]),
        .cnt_en        (cfg_q[MW_CNTEN_BIT]),
        .hit           (hits[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // config register, combine and delta mode bits, threshold and count shadows
  always_comb begin
    cfg_d = cfg_q;
    and_d = and_q;
    base_d = base_q;
    for (int i = 0; i < MW_AXES; i++) begin
      th_d[i] = th_q[i];
      cnt_d[i] = cnt_q[i];
    end
    if (reg_wr && reg_addr == MW_ADDR_CFG) begin
      cfg_d = reg_wdata;
    end
    if (reg_wr && reg_addr == MW_ADDR_THRESH) begin
      and_d = reg_wdata[MW_AND_BIT];
      base_d = reg_wdata[MW_BASE_BIT];
      for (int i = 0; i < MW_AXES; i++) begin
        if (sel == MW_SEL_TH_X + 3'(i)) begin
          th_d[i] = reg_wdata[MW_TH_W-1:0];
        end
        if (sel == MW_SEL_CNT_X + 3'(i)) begin
          cnt_d[i] = reg_wdata[MW_TH_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= MW_CFG_RST;
      and_q <= 1'b0;
      base_q <= 1'b0;
      for (int i = 0; i < MW_AXES; i++) begin
        th_q[i] <= '0;
        cnt_q[i] <= '0;
      end
    end else begin
      cfg_q <= cfg_d;
      and_q <= and_d;
      base_q <= base_d;
      for (int i = 0; i < MW_AXES; i++) begin
        th_q[i] <= th_d[i];
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wakeup level, sticky status, mask and interrupt level
  always_comb begin
    any_hit = |(hits & axis_active);
    all_hit = (|axis_active) && ((hits & axis_active) == axis_active);
    wake_now = and_q ? all_hit : any_hit;
    wake_d = clr ? 1'b0 : wake_now;
    mask_d = mask_q;
    stat_d = stat_q;
    if (reg_wr && reg_addr == MW_ADDR_MASK) begin
      mask_d = reg_wdata[0];
    end
    if (reg_wr && reg_addr == MW_ADDR_STAT) begin
      stat_d = stat_q & ~reg_wdata[0];
    end
    // a new wakeup in the cycle of a clear keeps the bit set
    if (wake_d && !wake_q) begin
      stat_d = 1'b1;
    end
    irq_d = stat_d & mask_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, zero except in the cycle after a read strobe
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        MW_ADDR_CFG: rdata_d = cfg_q;
        MW_ADDR_THRESH: begin
          rdata_d = {base_q, and_q, 6'h00};
          for (int i = 0; i < MW_AXES; i++) begin
            if (sel == MW_SEL_TH_X + 3'(i)) rdata_d[MW_TH_W-1:0] = th_q[i];
            if (sel == MW_SEL_CNT_X + 3'(i)) rdata_d[MW_TH_W-1:0] = cnt_q[i];
          end
        end
        MW_ADDR_STAT: rdata_d = {7'h00, stat_q};
        MW_ADDR_MASK: rdata_d = {7'h00, mask_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign wakeup = wake_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  cfg_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == MW_ADDR_CFG) |=> cfg_q == $past(cfg_q))
    else $error("cfg changed");
  cfg_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == MW_ADDR_CFG) |=> cfg_q == $past(reg_wdata))
    else $error("cfg lost");
  cfg_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == MW_ADDR_CFG) |=> reg_rdata == $past(cfg_q))
    else $error("cfg read back");
  reset_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr |=> !wakeup)
    else $error("wake during reset");
  hold_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr |=> hits == '0)
    else $error("axis hit kept during reset");
  shadow_x_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == MW_ADDR_THRESH && sel == MW_SEL_TH_X)
    |=> th_q[0] == $past(reg_wdata[5:0])) else $error("x threshold");
  shadow_y_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == MW_ADDR_THRESH && sel == MW_SEL_TH_X + 3'h1)
    |=> th_q[1] == $past(reg_wdata[5:0])) else $error("y threshold");
  count_x_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == MW_ADDR_THRESH && sel == MW_SEL_CNT_X)
    |=> cnt_q[0] == $past(reg_wdata[5:0]) && th_q[0] == $past(th_q[0])) else $error("x count");
  count_z_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == MW_ADDR_THRESH && sel == 3'h7)
    |=> cnt_q[2] == $past(reg_wdata[5:0]) && th_q[2] == $past(th_q[2])) else $error("z count");
  none_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == MW_ADDR_THRESH && sel[1:0] == 2'h0)
    |=> th_q[0] == $past(th_q[0]) && cnt_q[0] == $past(cnt_q[0])) else $error("none sel");
  mode_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == MW_ADDR_THRESH) |=> base_q == $past(reg_wdata[MW_BASE_BIT])
    && and_q == $past(reg_wdata[MW_AND_BIT])) else $error("mode bits");
  or_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!and_q && !clr && |(hits & axis_active)) |=> wakeup)
    else $error("or wake");
  and_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (and_q && (hits & axis_active) != axis_active) |=> !wakeup)
    else $error("and wake");
  stat_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(wakeup) |-> stat_q)
    else $error("status not set");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stat_q && mask_q && !reg_wr) |=> irq)
    else $error("irq");
  irq_masked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!mask_q && !reg_wr) |=> !irq)
    else $error("irq while masked");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside read");
endmodule

//--- dv/mw_tb.sv
// self-checking bench for the motion-watch configuration block
`timescale 1ns/1ps
module testbench;
  import mw_pkg::*;
  logic                   sys_clk      = 1'b0;
  logic                   rst_n        = 1'b0;
  logic [MW_AW-1:0]       reg_addr     = '0;
  logic [MW_DW-1:0]       reg_wdata    = '0;
  logic                   reg_wr       = 1'b0;
  logic                   reg_rd       = 1'b0;
  logic [MW_DW-1:0]       reg_rdata;
  logic                   sample_valid = 1'b0;
  logic [MW_SAMPLE_W-1:0] sample_x     = '0;
  logic [MW_SAMPLE_W-1:0] sample_y     = '0;
  logic [MW_SAMPLE_W-1:0] sample_z     = '0;
  logic [MW_AXES-1:0]     axis_active  = 3'h1;
  logic                   wakeup;
  logic                   irq;
  int                     n_mismatch   = 0;
  int                     n_compared   = 0;
  int                     cycles       = 0;

  mw_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
    .axis_active(axis_active), .wakeup(wakeup), .irq(irq));

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t output level %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic smp(input int v);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_x     <= v[MW_SAMPLE_W-1:0];
    @(posedge sys_clk);
    sample_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // each shadow keeps its own value; selects 000 and 100 reach nothing
  task automatic shadow_rw();
    for (int s = 1; s < 8; s++) begin
      wr(MW_ADDR_CFG, 8'(s));
      wr(MW_ADDR_THRESH, (s == 4) ? 8'h3F : 8'(s * 9));
    end
    wr(MW_ADDR_CFG, 8'h00);
    wr(MW_ADDR_THRESH, 8'h3F);
    rd(MW_ADDR_THRESH, 8'h00);
    for (int s = 1; s < 8; s++) begin
      wr(MW_ADDR_CFG, 8'(s));
      rd(MW_ADDR_THRESH, (s == 4) ? 8'h00 : 8'(s * 9));
    end
  endtask

  // hold the watch in reset, load X threshold and count, release, move X by d per sample
  task automatic det(input logic [7:0] cfg, input logic [7:0] th, input logic [5:0] cnt,
                     input int d, input int n, input logic [2:0] act, input logic exp);
    wr(MW_ADDR_CFG, 8'h80 | MW_SEL_TH_X);
    axis_active <= act;
    wr(MW_ADDR_THRESH, th);
    #1;
    chk1(wakeup, 1'b0);
    wr(MW_ADDR_CFG, 8'h80 | MW_SEL_CNT_X);
    wr(MW_ADDR_THRESH, {th[7:6], cnt});
    wr(MW_ADDR_CFG, cfg);
    for (int k = 0; k <= n; k++) smp(k * d);
    repeat (4) @(posedge sys_clk);
    #1;
    chk1(wakeup, exp);
  endtask

  // samples while the watch is held in reset raise nothing; releasing it re-arms detection
  task automatic manual_hold();
    wr(MW_ADDR_CFG, 8'h80);
    smp(0);
    smp(40);
    repeat (4) @(posedge sys_clk);
    #1;
    chk1(wakeup, 1'b0);
    wr(MW_ADDR_CFG, 8'h00);
    smp(0);
    smp(40);
    repeat (4) @(posedge sys_clk);
    #1;
    chk1(wakeup, 1'b1);
    rd(MW_ADDR_CFG, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(MW_ADDR_CFG, MW_CFG_RST);
    rd(MW_ADDR_MASK, 8'h00);
    rd(8'h20, 8'h00);
    shadow_rw();
    wr(MW_ADDR_CFG, 8'hDB);
    repeat (6) @(posedge sys_clk);
    rd(MW_ADDR_CFG, 8'hDB);
    wr(MW_ADDR_MASK, 8'h01);
    det(8'h00, 8'h0A, 6'h0, 10, 1, 3'h1, 1'b0);
    det(8'h00, 8'h0A, 6'h0, 11, 1, 3'h1, 1'b1);
    rd(MW_ADDR_STAT, 8'h01);
    chk1(irq, 1'b1);
    wr(MW_ADDR_MASK, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    chk1(irq, 1'b0);
    wr(MW_ADDR_MASK, 8'h01);
    wr(MW_ADDR_STAT, 8'h01);
    rd(MW_ADDR_STAT, 8'h00);
    chk1(irq, 1'b0);
    det(8'h20, 8'h0A, 6'h0, 40, 1, 3'h1, 1'b0);
    det(8'h20, 8'h0A, 6'h0, 44, 1, 3'h1, 1'b1);
    det(8'h00, 8'h3E, 6'h0, 100, 1, 3'h1, 1'b1);
    det(8'h60, 8'h0C, 6'h0, 400, 1, 3'h1, 1'b0);
    det(8'h70, 8'h0B, 6'h0, 400, 1, 3'h1, 1'b1);
    det(8'h50, 8'h0B, 6'h0, 400, 1, 3'h1, 1'b1);
    det(8'h08, 8'h05, 6'h1, 10, 1, 3'h1, 1'b0);
    det(8'h08, 8'h05, 6'h1, 10, 2, 3'h1, 1'b1);
    det(8'h08, 8'h05, 6'h0, 10, 1, 3'h1, 1'b1);
    det(8'h00, 8'h45, 6'h0, 10, 1, 3'h3, 1'b0);
    det(8'h00, 8'h05, 6'h0, 10, 1, 3'h3, 1'b1);
    det(8'h00, 8'h8A, 6'h0, 6, 2, 3'h1, 1'b1);
    det(8'h00, 8'h0A, 6'h0, 6, 2, 3'h1, 1'b0);
    det(8'h40, 8'h0A, 6'h0, 176, 1, 3'h1, 1'b1);
    manual_hold();
    finish_test();
  end
endmodule
